/* shared/gg_pkg.sv */
// Shared constants and types for the gauge command port and its bus controller
package gg_pkg;
	// Target addressing
	localparam logic [6:0] DEV_ADDR = 7'h55;
	localparam logic [7:0] ADDR_WR = 8'haa;
	localparam logic [7:0] ADDR_RD = 8'hab;
	localparam logic [7:0] CMD_MAX = 8'h6b;

	// Command space of the gauge
	localparam int MEM_N = 108;
	localparam logic [7:0] OFS_PROFILE = 8'h6a;
	localparam logic [7:0] OFS_FLAGS = 8'h06;
	localparam int FLAG_DONE = 0;
	localparam int FLAG_INVALID = 1;
	localparam int PROFILE_BIT = 0;
	localparam logic [7:0] WR0_LO = 8'h00;
	localparam logic [7:0] WR0_HI = 8'h01;
	localparam logic [7:0] WR1_LO = 8'h3e;
	localparam logic [7:0] WR1_HI = 8'h61;

	// Timing, figures in their own units, counts derived at 100 MHz
	localparam int CLK_NS = 10;
	localparam int NS_PER_US = 1000;
	localparam int NS_PER_MS = 1000000;
	localparam int NS_PER_S = 1000000000;
	localparam int T_TMO_UNIT_MS = 500;
	localparam int TMO_UNIT_CYC = T_TMO_UNIT_MS * NS_PER_MS / CLK_NS;
	localparam int T_STR_FLASH_MS = 80;
	localparam int STR_FLASH_CYC = T_STR_FLASH_MS * NS_PER_MS / CLK_NS;
	localparam int T_STR_OCV_MS = 270;
	localparam int STR_OCV_CYC = T_STR_OCV_MS * NS_PER_MS / CLK_NS;
	localparam int T_WAIT_CTRL_US = 66;
	localparam int WAIT_CTRL_CYC = (T_WAIT_CTRL_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int T_WAIT_CSUM_MS = 100;
	localparam int WAIT_CSUM_CYC = T_WAIT_CSUM_MS * NS_PER_MS / CLK_NS;
	localparam int T_WAIT_OCV_MS = 1200;
	localparam int WAIT_OCV_CYC = T_WAIT_OCV_MS * NS_PER_MS / CLK_NS;
	localparam int T_WAIT_RW_S = 2;
	localparam int WAIT_RW_CYC = T_WAIT_RW_S * (NS_PER_S / CLK_NS);
	localparam int T_POLL_MS = 500;
	localparam int POLL_CYC = T_POLL_MS * NS_PER_MS / CLK_NS;
	localparam int T_BIT_NS = 2500;
	localparam int QTR_CYC = (T_BIT_NS / 4 + CLK_NS - 1) / CLK_NS;
	localparam int SETTLE_CYC = 4;

	// Controller registers, byte addresses
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_CMD = 5'h04;
	localparam logic [4:0] REG_TX = 5'h08;
	localparam logic [4:0] REG_RX = 5'h0c;
	localparam logic [4:0] REG_STAT = 5'h10;
	localparam int CTRL_GO = 0;
	localparam int CTRL_OP = 1;
	localparam int CTRL_TWO = 3;
	localparam int CTRL_WAIT = 4;
	localparam int STAT_BUSY = 0;
	localparam int STAT_NACK = 1;
	localparam int STAT_ERR = 2;
	localparam int STAT_DONE = 3;

	typedef enum logic [1:0] {
		OP_WRITE = 2'b00,
		OP_READ = 2'b01,
		OP_QREAD = 2'b10
	} gg_op_t;

	typedef enum logic [2:0] {
		W_NONE = 3'b000,
		W_CTRL = 3'b001,
		W_CSUM = 3'b010,
		W_OCV = 3'b011,
		W_RW = 3'b100,
		W_POLL = 3'b101
	} gg_wait_t;
endpackage

/* shared/gg_i2c_if.sv */
`timescale 1ns/100ps
// Two-wire bus joining the gauge command port and its controller
interface gg_i2c_if;
	logic dev_scl_o;
	logic dev_scl_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic scl;
	logic sda;

	// Open drain: a line is high unless a party drives it
	assign scl = (dev_scl_oe ? dev_scl_o : 1'b1) & (host_scl_oe ? host_scl_o : 1'b1);
	assign sda = (dev_sda_oe ? dev_sda_o : 1'b1) & (host_sda_oe ? host_sda_o : 1'b1);

	modport dev (input scl, input sda, output dev_scl_o, output dev_scl_oe,
		output dev_sda_o, output dev_sda_oe);
	modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
		output host_sda_o, output host_sda_oe);
endinterface

/* rtl/gg_dev.sv */
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/100ps
// Gauge command port: two-wire target with pointer, timeout release and clock stretch
module gg_dev
	import gg_pkg::*;
#(
	parameter int TMO_UNIT = TMO_UNIT_CYC,
	parameter int STR_FLASH = STR_FLASH_CYC,
	parameter int STR_OCV = STR_OCV_CYC
) (
	// Clock, reset, enable
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Bus
	gg_i2c_if.dev bus,
	// Gauge core side
	input wire logic [7:0] i_timeout,
	input wire logic i_last_profile,
	input wire logic i_ocv_done,
	input wire logic i_ocv_invalid,
	input wire logic i_flash_busy,
	input wire logic i_ocv_busy,
	output logic o_wr_valid,
	output logic [7:0] o_wr_addr,
	output logic [7:0] o_wr_data,
	output logic o_sleep
);
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_ADDR = 4'h1,
		S_AACK = 4'h2,
		S_CMD = 4'h3,
		S_CACK = 4'h4,
		S_WR = 4'h5,
		S_WACK = 4'h6,
		S_RD = 4'h7,
		S_RACK = 4'h8,
		S_IGN = 4'h9
	} gg_dstate_t;

	typedef struct packed {
		logic [1:0] scl_sy;
		logic [1:0] sda_sy;
		logic scl_p;
		logic sda_p;
		gg_dstate_t st;
		logic [3:0] bc;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic rw;
		logic mack;
		logic [7:0] rdata;
		logic sda_oe;
		logic scl_oe;
		logic [MEM_N-1:0][7:0] mem;
		logic done;
		logic invalid;
		logic [31:0] hs_cnt;
		logic [7:0] ticks;
		logic rel;
		logic [2:0] settle;
		logic sleep;
		logic [31:0] str_cnt;
		logic wr_v;
		logic [7:0] wr_a;
		logic [7:0] wr_d;
	} gg_dev_st_t;

	gg_dev_st_t q;
	gg_dev_st_t d;

	function automatic logic [7:0] rd_byte(input gg_dev_st_t s, input logic [7:0] p,
		input logic prof);
		logic [7:0] b;
		b = 8'h00;
		if (p == OFS_PROFILE) begin
			b[PROFILE_BIT] = prof;
		end else if (p == OFS_FLAGS) begin
			b[FLAG_DONE] = s.done;
			b[FLAG_INVALID] = s.invalid;
		end else if (p <= CMD_MAX) begin
			b = s.mem[p[6:0]];
		end
		return b;
	endfunction

	function automatic logic writable(input logic [7:0] p);
		return (p >= WR0_LO && p <= WR0_HI) || (p >= WR1_LO && p <= WR1_HI);
	endfunction

	logic scl;
	logic sda;
	logic start;
	logic stop;
	logic rise;
	logic fall;
	logic low;
	logic busy;
	logic [31:0] lim;
	logic [7:0] cur_b;
	logic [7:0] nxt_b;
	logic [7:0] ptr_n;

	always_comb begin
		scl = q.scl_sy[1];
		sda = q.sda_sy[1];
		start = q.scl_p & scl & q.sda_p & ~sda;
		stop = q.scl_p & scl & ~q.sda_p & sda;
		rise = ~q.scl_p & scl;
		fall = q.scl_p & ~scl;
		low = ~scl | ~sda;
		busy = i_flash_busy | i_ocv_busy;
		lim = i_ocv_busy ? 32'(STR_OCV) : 32'(STR_FLASH);
		ptr_n = q.ptr + 8'h01;
		cur_b = rd_byte(q, q.ptr, i_last_profile);
		nxt_b = rd_byte(q, ptr_n, i_last_profile);
		d = q;
		d.scl_sy = {q.scl_sy[0], bus.scl};
		d.sda_sy = {q.sda_sy[0], bus.sda};
		d.scl_p = scl;
		d.sda_p = sda;
		d.wr_v = 1'b0;

		// Bus engine
		if (start) begin
			d.st = S_ADDR;
			d.bc = 4'h0;
			d.sda_oe = 1'b0;
		end else if (stop) begin
			d.st = S_IDLE;
			d.sda_oe = 1'b0;
		end else if (rise) begin
			unique case (q.st)
				S_ADDR, S_CMD, S_WR: begin
					d.sh = {q.sh[6:0], sda};
					d.bc = q.bc + 4'h1;
				end
				S_RACK: d.mack = ~sda;
				default: ;
			endcase
		end else if (fall) begin
			unique case (q.st)
				S_ADDR: begin
					if (q.bc == 4'h8) begin
						if (q.sh[7:1] == DEV_ADDR) begin
							d.rw = q.sh[0];
							d.sda_oe = 1'b1;
							d.st = S_AACK;
							d.sleep = 1'b0;
						end else begin
							d.st = S_IGN;
						end
					end
				end
				S_AACK: begin
					d.bc = 4'h0;
					if (q.rw) begin
						d.rdata = cur_b;
						d.sda_oe = ~cur_b[7];
						d.bc = 4'h1;
						d.st = S_RD;
						if (q.ptr == OFS_FLAGS) begin
							d.done = 1'b0;
						end
					end else begin
						d.sda_oe = 1'b0;
						d.st = S_CMD;
					end
				end
				S_CMD: begin
					if (q.bc == 4'h8) begin
						if (q.sh <= CMD_MAX) begin
							d.ptr = q.sh;
							d.sda_oe = 1'b1;
							d.st = S_CACK;
						end else begin
							d.st = S_IGN;
						end
					end
				end
				S_CACK, S_WACK: begin
					d.sda_oe = 1'b0;
					d.bc = 4'h0;
					d.st = S_WR;
				end
				S_WR: begin
					if (q.bc == 4'h8) begin
						if (writable(q.ptr)) begin
							d.mem[q.ptr[6:0]] = q.sh;
							d.wr_v = 1'b1;
							d.wr_a = q.ptr;
							d.wr_d = q.sh;
							d.ptr = ptr_n;
							d.sda_oe = 1'b1;
							d.st = S_WACK;
						end else begin
							d.st = S_IGN;
						end
					end
				end
				S_RD: begin
					if (q.bc == 4'h8) begin
						d.sda_oe = 1'b0;
						d.st = S_RACK;
					end else begin
						d.sda_oe = ~q.rdata[6];
						d.rdata = {q.rdata[6:0], 1'b0};
						d.bc = q.bc + 4'h1;
					end
				end
				S_RACK: begin
					if (q.mack) begin
						d.ptr = ptr_n;
						d.rdata = nxt_b;
						d.sda_oe = ~nxt_b[7];
						d.bc = 4'h1;
						d.st = S_RD;
						if (ptr_n == OFS_FLAGS) begin
							d.done = 1'b0;
						end
					end else begin
						d.st = S_IGN;
					end
				end
				default: ;
			endcase
		end

		// Clock stretch, only outside S_IDLE and S_IGN, so also in another target's address byte, and bounded; it starts only
		// at a seen fall, so a clock the master has just released is never pulled back
		if (busy && !q.rel && q.st != S_IDLE && q.st != S_IGN &&
			(q.scl_oe || fall) && q.str_cnt < lim) begin
			d.scl_oe = 1'b1;
			d.str_cnt = q.str_cnt + 32'h1;
		end else begin
			d.scl_oe = 1'b0;
			if (!busy) begin
				d.str_cnt = 32'h0;
			end
		end

		// Low-hold timeout; the sub-counter keeps the compare narrow
		if (!low || i_timeout == 8'h00) begin
			d.hs_cnt = 32'h0;
			d.ticks = 8'h00;
			d.rel = 1'b0;
			d.settle = 3'h0;
		end else if (q.rel) begin
			if (q.settle == 3'(SETTLE_CYC - 1)) begin
				d.sleep = 1'b1;
			end else begin
				d.settle = q.settle + 3'h1;
			end
		end else if (q.ticks == i_timeout) begin
			d.rel = 1'b1;
			d.sda_oe = 1'b0;
			d.scl_oe = 1'b0;
			d.st = S_IDLE;
		end else if (q.hs_cnt == 32'(TMO_UNIT - 1)) begin
			d.hs_cnt = 32'h0;
			d.ticks = q.ticks + 8'h01;
		end else begin
			d.hs_cnt = q.hs_cnt + 32'h1;
		end

		// Set wins over a read clear in the same cycle
		if (i_ocv_done) begin
			d.done = 1'b1;
			d.invalid = i_ocv_invalid;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			q <= '0;
		end else if (i_ce) begin
			q <= d;
		end
	end

	assign bus.dev_scl_o = 1'b0;
	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_scl_oe = q.scl_oe;
	assign bus.dev_sda_oe = q.sda_oe;
	assign o_wr_valid = q.wr_v;
	assign o_wr_addr = q.wr_a;
	assign o_wr_data = q.wr_d;
	assign o_sleep = q.sleep;
endmodule // gg_dev

/* rtl/gg_host.sv */
`timescale 1ns/100ps
// Bus controller: Avalon-MM registers driving two-wire transfers to the gauge
module gg_host
	import gg_pkg::*;
#(
	parameter int WAIT_CTRL = WAIT_CTRL_CYC,
	parameter int WAIT_CSUM = WAIT_CSUM_CYC,
	parameter int WAIT_OCV = WAIT_OCV_CYC,
	parameter int WAIT_RW = WAIT_RW_CYC,
	parameter int WAIT_POLL = POLL_CYC,
	parameter int STR_MAX = STR_OCV_CYC
) (
	// Clock, reset, enable
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Avalon-MM slave
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Bus
	gg_i2c_if.host bus
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_GAP = 3'b001,
		H_START = 3'b010,
		H_BIT = 3'b011,
		H_STOP = 3'b100
	} gg_hstate_t;

	typedef enum logic [2:0] {
		P_AW = 3'b000,
		P_CMD = 3'b001,
		P_D0 = 3'b010,
		P_D1 = 3'b011,
		P_AR = 3'b100,
		P_R0 = 3'b101,
		P_R1 = 3'b110
	} gg_phase_t;

	typedef struct packed {
		logic [1:0] scl_sy;
		logic [1:0] sda_sy;
		gg_hstate_t st;
		gg_phase_t ph;
		gg_op_t op;
		logic two;
		gg_wait_t wsel;
		logic [7:0] cmd;
		logic [15:0] tx;
		logic [15:0] rx;
		logic busy;
		logic nack;
		logic err;
		logic done;
		logic [7:0] sh;
		logic [3:0] bi;
		logic [1:0] qp;
		logic [7:0] qc;
		logic scl_oe;
		logic sda_oe;
		logic [31:0] gap;
		logic [31:0] str;
		logic ws;
		logic [31:0] rdata;
	} gg_host_st_t;

	gg_host_st_t q;
	gg_host_st_t d;

	function automatic logic [7:0] ph_byte(input gg_host_st_t s, input gg_phase_t p);
		unique case (p)
			P_AW: return ADDR_WR;
			P_CMD: return s.cmd;
			P_D0: return s.tx[7:0];
			P_D1: return s.tx[15:8];
			P_AR: return ADDR_RD;
			default: return 8'hff;
		endcase
	endfunction

	function automatic logic [31:0] gap_of(input gg_wait_t w);
		unique case (w)
			W_CTRL: return 32'(WAIT_CTRL);
			W_CSUM: return 32'(WAIT_CSUM);
			W_OCV: return 32'(WAIT_OCV);
			W_RW: return 32'(WAIT_RW);
			W_POLL: return 32'(WAIT_POLL);
			default: return 32'h0;
		endcase
	endfunction

	logic scl;
	logic sda;
	logic req;
	logic wr_do;
	logic hold;
	logic tick;
	logic rxing;
	gg_phase_t nph;

	always_comb begin
		scl = q.scl_sy[1];
		sda = q.sda_sy[1];
		req = i_avs_read | i_avs_write;
		wr_do = i_avs_write & q.ws;
		rxing = q.ph == P_R0 || q.ph == P_R1;
		hold = (q.st == H_START || q.st == H_BIT || q.st == H_STOP) && q.qp == 2'h1 && !scl;
		tick = q.qc == 8'(QTR_CYC - 1);
		nph = q.ph;
		d = q;
		d.scl_sy = {q.scl_sy[0], bus.scl};
		d.sda_sy = {q.sda_sy[0], bus.sda};
		d.ws = req & ~q.ws;
		if (q.gap != 32'h0) begin
			d.gap = q.gap - 32'h1;
		end

		// Register access, one wait state
		if (req && !q.ws) begin
			unique case (i_avs_address)
				REG_CTRL: d.rdata = {25'h0, q.wsel, q.two, q.op, 1'b0};
				REG_CMD: d.rdata = {24'h0, q.cmd};
				REG_TX: d.rdata = {16'h0, q.tx};
				REG_RX: d.rdata = {16'h0, q.rx};
				REG_STAT: d.rdata = {28'h0, q.done, q.err, q.nack, q.busy};
				default: d.rdata = 32'h0;
			endcase
		end
		if (wr_do) begin
			unique case (i_avs_address)
				REG_CTRL: begin
					if (i_avs_writedata[CTRL_GO] && !q.busy) begin
						d.op = gg_op_t'(i_avs_writedata[CTRL_OP +: 2]);
						d.two = i_avs_writedata[CTRL_TWO];
						d.wsel = gg_wait_t'(i_avs_writedata[CTRL_WAIT +: 3]);
						d.busy = 1'b1;
						d.nack = 1'b0;
						d.err = 1'b0;
						d.st = H_GAP;
					end
				end
				REG_CMD: d.cmd = i_avs_writedata[7:0];
				REG_TX: d.tx = i_avs_writedata[15:0];
				REG_STAT: begin
					if (i_avs_writedata[STAT_DONE]) begin
						d.done = 1'b0;
					end
				end
				default: ;
			endcase
		end

		// Bit engine in quarter periods; released SCL waits for the line
		if (hold) begin
			d.qc = 8'h0;
			d.str = q.str + 32'h1;
			if (q.str == 32'(STR_MAX)) begin
				d.err = 1'b1;
				d.scl_oe = 1'b0;
				d.sda_oe = 1'b0;
				d.busy = 1'b0;
				d.done = 1'b1;
				d.st = H_IDLE;
			end
		end else if (q.st == H_GAP) begin
			if (q.gap == 32'h0) begin
				d.st = H_START;
				d.qp = 2'h0;
				d.qc = 8'h0;
				d.sda_oe = 1'b0;
				d.ph = q.op == OP_QREAD ? P_AR : P_AW;
			end
		end else if (q.st != H_IDLE) begin
			d.str = 32'h0;
			d.qc = tick ? 8'h0 : q.qc + 8'h1;
			if (tick) begin
				d.qp = q.qp + 2'h1;
				unique case (q.st)
					H_START: begin
						unique case (q.qp)
							2'h0: d.scl_oe = 1'b0;
							2'h1: d.sda_oe = 1'b1;
							2'h2: d.scl_oe = 1'b1;
							default: begin
								d.st = H_BIT;
								d.bi = 4'h0;
								d.sh = ph_byte(q, q.ph);
								d.sda_oe = ~d.sh[7];
							end
						endcase
					end
					H_BIT: begin
						unique case (q.qp)
							2'h0: d.scl_oe = 1'b0;
							2'h1: ;
							2'h2: begin
								d.scl_oe = 1'b1;
								if (q.bi != 4'h8) begin
									d.sh = {q.sh[6:0], sda};
								end else if (!rxing && sda) begin
									d.nack = 1'b1;
								end
							end
							default: begin
								if (q.bi != 4'h8) begin
									d.bi = q.bi + 4'h1;
									if (q.bi == 4'h7) begin
										d.sda_oe = rxing && q.ph == P_R0 && q.two;
									end else begin
										d.sda_oe = !rxing && !q.sh[7];
									end
								end else begin
									unique case (q.ph)
										P_AW: nph = P_CMD;
										P_CMD: nph = q.op == OP_WRITE ? P_D0 : P_AR;
										P_D0: nph = q.two ? P_D1 : P_AW;
										P_AR: nph = P_R0;
										P_R0: nph = q.two ? P_R1 : P_AW;
										default: nph = P_AW;
									endcase
									if (q.ph == P_R0) begin
										d.rx[7:0] = q.sh;
									end
									if (q.ph == P_R1) begin
										d.rx[15:8] = q.sh;
									end
									d.ph = nph;
									d.bi = 4'h0;
									if (q.nack || nph == P_AW) begin
										d.st = H_STOP;
										d.sda_oe = 1'b1;
									end else if (q.ph == P_CMD && nph == P_AR) begin
										d.st = H_START;
										d.sda_oe = 1'b0;
									end else begin
										d.sh = ph_byte(q, nph);
										d.sda_oe = nph != P_R0 && nph != P_R1 &&
											!d.sh[7];
									end
								end
							end
						endcase
					end
					H_STOP: begin
						unique case (q.qp)
							2'h0: d.scl_oe = 1'b0;
							2'h1: ;
							2'h2: d.sda_oe = 1'b0;
							default: begin
								d.st = H_IDLE;
								d.busy = 1'b0;
								d.done = 1'b1;
								d.gap = gap_of(q.wsel);
							end
						endcase
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			q <= '0;
		end else if (i_ce) begin
			q <= d;
		end
	end

	assign o_avs_readdata = q.rdata;
	assign o_avs_waitrequest = req & ~q.ws;
	assign bus.host_scl_o = 1'b0;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_scl_oe = q.scl_oe;
	assign bus.host_sda_oe = q.sda_oe;
endmodule // gg_host

/* tb/gg_monitor.sv */
`timescale 1ns/100ps
// Checker on the bus between the controller and the gauge port
module gg_monitor
	import gg_pkg::*;
#(
	parameter int STR_OCV = STR_OCV_CYC
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Bus
	input wire logic dev_scl_o,
	input wire logic dev_scl_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic scl_q, sda_q, rd_q;
	logic [3:0] bit_q;
	logic [2:0] byte_q;
	logic [7:0] sh_q, cmd_q;
	logic [15:0] str_q;
	logic ack9;
	assign ack9 = scl & ~scl_q & (bit_q == 4'h8);
	// A start clears the count, so a repeated start begins a fresh address byte
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			rd_q <= 1'b0;
			bit_q <= 4'h0;
			byte_q <= 3'h0;
			sh_q <= 8'h00;
			cmd_q <= 8'h00;
			str_q <= 16'h0000;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			str_q <= dev_scl_oe ? str_q + 16'h0001 : 16'h0000;
			if (scl && scl_q && sda_q && !sda) begin
				bit_q <= 4'h0;
				byte_q <= 3'h0;
			end else if (ack9) begin
				bit_q <= 4'h0;
				byte_q <= byte_q + 3'h1;
				rd_q <= (byte_q == 3'h0) ? sh_q[0] : rd_q;
				cmd_q <= (byte_q == 3'h1) ? sh_q : cmd_q;
			end else if (scl && !scl_q) begin
				bit_q <= bit_q + 4'h1;
				sh_q <= {sh_q[6:0], sda};
			end
		end
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	a_sda_open_drain: assert property (dev_sda_oe |-> !dev_sda_o)
		else $error("device drives data line high");
	a_scl_open_drain: assert property (dev_scl_oe |-> !dev_scl_o)
		else $error("device drives clock line high");
	a_sda_hold_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
		else $error("device moved data while clock high");
	a_stretch_low: assert property ($rose(dev_scl_oe) |-> !$past(scl))
		else $error("stretch began with clock high");
	a_stretch_max: assert property (str_q <= STR_OCV)
		else $error("clock stretch too long");
	a_addr_form: assert property (ack9 && byte_q == 3'h0 |-> sh_q[7:1] == DEV_ADDR)
		else $error("wrong target address sent");
	a_addr_ack: assert property (ack9 && byte_q == 3'h0 |-> !sda)
		else $error("own address not acknowledged");
	a_cmd_ack: assert property (ack9 && byte_q == 3'h1 && !rd_q |-> sda == (sh_q > CMD_MAX))
		else $error("command byte answer wrong");
	a_ro_nack: assert property (ack9 && byte_q == 3'h2 && !rd_q && cmd_q == OFS_PROFILE |-> sda)
		else $error("read-only write acknowledged");
	c_stretch: cover property (str_q == 16'd20);
	c_cmd_nack: cover property (ack9 && byte_q == 3'h1 && !rd_q && sh_q > CMD_MAX);
	c_ro_write: cover property (ack9 && byte_q == 3'h2 && cmd_q == OFS_PROFILE);
endmodule // gg_monitor

/* tb/tb.sv */
`timescale 1ns/100ps
// Testbench: controller and gauge port on one bus, a bench-driven second gauge port
module tb;
	import gg_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic ce = 1'b1, rd = 1'b0, wr = 1'b0, prof = 1'b0, done = 1'b0, inval = 1'b0, fbusy = 1'b0;
	logic obusy = 1'b0;
	logic [4:0] adr = 5'h00;
	logic [31:0] wdat = 32'h0;
	logic [7:0] tmo = 8'h02;
	logic wreq, wv, slp2, ack;
	logic [7:0] wa, wd;
	logic [31:0] rdat, rv, st;
	logic [15:0] wq[$];
	int fail_count = 0;
	int check_count = 0;
	gg_i2c_if bus();
	gg_i2c_if bus2();
	gg_host u_gg_host (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(ce), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
		.o_avs_waitrequest(wreq), .bus(bus.host));
	// Full-length timeout unit here, so the low-hold release never cuts a bus transfer
	gg_dev #(.STR_FLASH(100), .STR_OCV(300)) u_gg_dev (.i_mclk(i_mclk),
		.i_rst(i_rst), .i_ce(ce), .bus(bus.dev), .i_timeout(tmo), .i_last_profile(prof),
		.i_ocv_done(done), .i_ocv_invalid(inval), .i_flash_busy(fbusy), .i_ocv_busy(obusy),
		.o_wr_valid(wv), .o_wr_addr(wa), .o_wr_data(wd), .o_sleep());
	gg_dev #(.TMO_UNIT(200)) u_gg_dev_b (.i_mclk(i_mclk),
		.i_rst(i_rst), .i_ce(ce), .bus(bus2.dev), .i_timeout(tmo), .i_last_profile(prof),
		.i_ocv_done(done), .i_ocv_invalid(inval), .i_flash_busy(fbusy), .i_ocv_busy(obusy),
		.o_wr_valid(), .o_wr_addr(), .o_wr_data(), .o_sleep(slp2));
	gg_monitor #(.STR_OCV(300)) u_gg_monitor (.i_mclk(i_mclk), .i_rst(i_rst),
		.dev_scl_o(bus.dev_scl_o), .dev_scl_oe(bus.dev_scl_oe), .dev_sda_o(bus.dev_sda_o),
		.dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));
	always #5 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		if (wv === 1'b1) begin
			wq.push_back({wa, wd});
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (fail_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic hang();
		chk(32'h1, 32'h0);
		tally_and_finish();
	endtask

	// Avalon access; the request stands until waitrequest is seen low
	task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_mclk);
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= ~w;
		do begin
			@(posedge i_mclk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		rv = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		if (wreq !== 1'b0) hang();
	endtask

	// One transfer: load command and data, start, wait until idle, fetch the result
	task automatic xfer(input logic [7:0] ctl, input logic [7:0] cmd, input logic [15:0] tx);
		int n;
		n = 0;
		av(1'b1, REG_CMD, {24'h0, cmd});
		av(1'b1, REG_TX, {16'h0, tx});
		av(1'b1, REG_CTRL, {24'h0, ctl});
		do begin
			av(1'b0, REG_STAT, 32'h0);
			n++;
		end while ((rv[STAT_DONE] !== 1'b1 || rv[STAT_BUSY] !== 1'b0) && n < 9000);
		st = rv;
		if (st[STAT_DONE] !== 1'b1 || st[STAT_BUSY] !== 1'b0) hang();
		av(1'b1, REG_STAT, 32'h8);
		av(1'b0, REG_RX, 32'h0);
	endtask

	// Second port wires for one quarter bit; 1 leaves the line released
	task automatic bb(input logic c, input logic d);
		bus2.host_scl_oe <= ~c;
		bus2.host_sda_oe <= ~d;
		repeat (20) @(posedge i_mclk);
	endtask

	// Ends with the clock high in the acknowledge slot
	task automatic bb_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			bb(1'b0, b[i]);
			bb(1'b1, b[i]);
			bb(1'b1, b[i]);
			bb(1'b0, b[i]);
		end
		bb(1'b0, 1'b1);
		bb(1'b1, 1'b1);
		ack = ~bus2.sda;
	endtask

	task automatic bb_stop();
		bb(1'b0, 1'b1);
		bb(1'b0, 1'b0);
		bb(1'b1, 1'b0);
		bb(1'b1, 1'b1);
	endtask

	task automatic t_regs();
		av(1'b0, REG_STAT, 32'h0);
		chk(rv, 32'h0);
		av(1'b1, 5'h1c, 32'hffff_ffff);
		av(1'b0, 5'h1c, 32'h0);
		chk(rv, 32'h0);
		// Enable low freezes the slave, so the request must keep waiting
		ce <= 1'b0;
		fork
			av(1'b1, REG_CMD, 32'h5a);
			begin
				repeat (10) @(posedge i_mclk);
				chk(wreq, 1'b1);
				ce <= 1'b1;
			end
		join
		av(1'b0, REG_CMD, 32'h0);
		chk(rv, 32'h5a);
	endtask

	// Two-byte write while the gauge stretches mid-frame, then read back two ways
	task automatic t_write_read();
		int n;
		wq.delete();
		fork
			begin
				repeat (3000) @(posedge i_mclk);
				fbusy <= 1'b1;
				repeat (400) @(posedge i_mclk);
				fbusy <= 1'b0;
			end
		join_none
		xfer(8'h19, 8'h3e, 16'h1234);
		chk({st[STAT_NACK], st[STAT_ERR]}, 2'b00);
		chk(wq.size(), 2);
		chk(wq[0], 16'h3e34);
		chk(wq[1], 16'h3f12);
		// The next start may come only after the control wait has run out
		fork
			xfer(8'h0b, 8'h3e, 16'h0000);
			begin
				n = 0;
				while (bus.sda === 1'b1 && n < 20000) begin
					@(posedge i_mclk);
					n++;
				end
				chk(n >= WAIT_CTRL_CYC, 1'b1);
			end
		join
		chk(rv[15:0], 16'h1234);
		xfer(8'h05, 8'h00, 16'h0000);
		chk(rv[7:0], 8'h12);
	endtask

	task automatic t_profile();
		prof <= 1'b1;
		xfer(8'h03, OFS_PROFILE, 16'h0000);
		chk(rv[PROFILE_BIT], 1'b1);
		prof <= 1'b0;
		xfer(8'h05, 8'h00, 16'h0000);
		chk(rv[PROFILE_BIT], 1'b0);
	endtask

	task automatic t_refusals();
		wq.delete();
		xfer(8'h01, OFS_PROFILE, 16'h00ff);
		chk(st[STAT_NACK], 1'b1);
		chk(wq.size(), 0);
		xfer(8'h03, 8'h6c, 16'h0000);
		chk(st[STAT_NACK], 1'b1);
	endtask

	task automatic t_flags();
		fork
			begin
				repeat (3000) @(posedge i_mclk);
				obusy <= 1'b1;
				repeat (600) @(posedge i_mclk);
				obusy <= 1'b0;
			end
		join_none
		done <= 1'b1;
		inval <= 1'b1;
		@(posedge i_mclk);
		done <= 1'b0;
		xfer(8'h03, OFS_FLAGS, 16'h0000);
		chk({rv[FLAG_INVALID], rv[FLAG_DONE]}, 2'b11);
		chk({st[STAT_NACK], st[STAT_ERR]}, 2'b00);
	endtask

	// Gauge holds its acknowledge, then the bench holds the data line low
	task automatic t_timeout();
		bb(1'b1, 1'b0);
		bb(1'b0, 1'b0);
		bb_byte(ADDR_WR);
		chk(ack, 1'b1);
		repeat (460) @(posedge i_mclk);
		chk({bus2.dev_sda_oe, slp2}, 2'b00);
		bb(1'b1, 1'b0);
		repeat (460) @(posedge i_mclk);
		chk({bus2.dev_scl_oe, bus2.dev_sda_oe, slp2}, 3'b001);
		bb(1'b1, 1'b1);
		bb(1'b1, 1'b0);
		bb(1'b0, 1'b0);
		bb_byte(8'hac);
		chk({ack, slp2}, 2'b01);
		bb_stop();
		bb(1'b1, 1'b0);
		bb(1'b0, 1'b0);
		bb_byte(ADDR_WR);
		chk({ack, slp2}, 2'b10);
		bb_stop();
	endtask

	initial begin
		bus2.host_scl_o = 1'b0;
		bus2.host_sda_o = 1'b0;
		bus2.host_scl_oe = 1'b0;
		bus2.host_sda_oe = 1'b0;
		repeat (2) @(posedge i_mclk);
		i_rst <= 1'b0;
		t_regs();
		t_write_read();
		t_profile();
		t_refusals();
		t_flags();
		t_timeout();
		tally_and_finish();
	end
endmodule // tb
